// *** evc_pkg.sv ***
`default_nettype none
package evc_pkg;
    // Source counts
    localparam int NUM_TRAPS = 8;
    localparam int NUM_IRQS = 118;
    localparam int NUM_VECTORS = 126;
    localparam int VEC_W = 7;
    localparam int PRIO_W = 3;
    localparam int LEVEL_W = 4;
    localparam int ADDR_W = 24;

    // Vector table placement, word addresses
    localparam logic [23:0] PRIMARY_TABLE_BASE = 24'h000004;
    localparam logic [23:0] ALT_TABLE_OFFSET = 24'h000100;
    localparam logic [23:0] RESET_PC = 24'h000000;

    // Position of the alternate-table select bit in interrupt_control_two
    localparam int ALT_TABLE_SELECT_BIT = 15;

    // Trap vector numbers
    localparam logic [6:0] TRAP_RESERVED0 = 7'h00;
    localparam logic [6:0] TRAP_OSC_FAIL = 7'h01;
    localparam logic [6:0] TRAP_ADDR_ERR = 7'h02;
    localparam logic [6:0] TRAP_STACK_ERR = 7'h03;
    localparam logic [6:0] TRAP_MATH_ERR = 7'h04;

    // Level given to traps so that they outrank every user level
    localparam logic [3:0] TRAP_LEVEL = 4'h8;
    // User level zero keeps a source from ever being taken
    localparam logic [2:0] PRIO_DISABLED = 3'h0;

    // Fixed latencies, in clock cycles
    localparam logic [3:0] ENTRY_CYCLES = 4'h3;
    localparam logic [3:0] RETURN_CYCLES = 4'h3;

    // Controller states, one-hot
    typedef enum logic [4:0] {
        EVC_BOOT = 5'h01,
        EVC_IDLE = 5'h02,
        EVC_ENTRY = 5'h04,
        EVC_SERVE = 5'h08,
        EVC_RETURN = 5'h10
    } evc_state_t;
endpackage
`default_nettype wire

// *** evc_arbiter.sv ***
`default_nettype none
module evc_arbiter
    import evc_pkg::*;
#(
    parameter int N_IRQ = NUM_IRQS
) (
    input wire logic [NUM_TRAPS-1:0] trap_pend,
    input wire logic [N_IRQ-1:0] irq_pend,
    input wire logic [N_IRQ*PRIO_W-1:0] irq_prio,
    output logic win_valid,
    output logic [VEC_W-1:0] win_vec,
    output logic [LEVEL_W-1:0] win_level
);
    logic [PRIO_W-1:0] prio_of [N_IRQ];
    logic [LEVEL_W-1:0] best_level;
    logic [VEC_W-1:0] best_vec;
    logic found;

    // Unpack per-source levels; level zero masks the source
    genvar g;
    generate
        for (g = 0; g < N_IRQ; g = g + 1) begin : g_prio
            assign prio_of[g] = irq_pend[g] ? irq_prio[g*PRIO_W +: PRIO_W] : PRIO_DISABLED;
        end
    endgenerate

    // Walk from the top so the lowest vector wins a tie
    always_comb begin
        best_level = '0;
        best_vec = '0;
        found = 1'b0;
        for (int i = N_IRQ - 1; i >= 0; i = i - 1) begin
            if (prio_of[i] != PRIO_DISABLED && {1'b0, prio_of[i]} >= best_level) begin // [RULE4] [RULE5]
                best_level = {1'b0, prio_of[i]};
                best_vec = VEC_W'(i + NUM_TRAPS);
                found = 1'b1;
            end
        end
        // Traps are non-maskable and sit below all interrupt vectors
        for (int t = NUM_TRAPS - 1; t >= 0; t = t - 1) begin
            if (trap_pend[t]) begin // [RULE2] [RULE5]
                best_level = TRAP_LEVEL;
                best_vec = VEC_W'(t);
                found = 1'b1;
            end
        end
        win_valid = found;
        win_vec = best_vec;
        win_level = best_level;
    end
endmodule
`default_nettype wire

// *** evc_vector_addr.sv ***
`default_nettype none
module evc_vector_addr
    import evc_pkg::*;
(
    input wire logic [VEC_W-1:0] vec_num,
    input wire logic alt_table_select,
    output logic [ADDR_W-1:0] fetch_addr
);
    // Pick primary or alternate base; same layout, 100h apart
    function automatic logic [ADDR_W-1:0] table_base(input logic alt);
        table_base = alt ? (PRIMARY_TABLE_BASE + ALT_TABLE_OFFSET) : PRIMARY_TABLE_BASE;
    endfunction

    // Two words per entry: one 24-bit address each
    always_comb begin
        fetch_addr = table_base(alt_table_select)
            + {{(ADDR_W-VEC_W-1){1'b0}}, vec_num, 1'b0}; // [RULE6] [RULE10] [RULE14]
    end
endmodule
`default_nettype wire

// *** evc_controller.sv ***
// Function
// [RULE1] Merge all peripheral requests into one request to the CPU core.
// [RULE2] Accept up to eight non-maskable trap sources beside maskable interrupts.
// [RULE3] Each maskable source has a software level; seven usable levels.
// [RULE4] Equal-level pending sources are resolved by a fixed order.
// [RULE5] Lower vector address wins ties; vector zero outranks all others.
// [RULE6] Primary table at 000004h, 126 entries: 8 traps then 118 interrupts.
// [RULE7] Every source maps to its own distinct vector entry.
// [RULE8] Each entry is a 24-bit service routine start address.
// [RULE9] Alternate-table select bit routes every vector to the alternate table.
// [RULE10] Alternate table mirrors primary, 100h higher; trap 0 at 000104h.
// [RULE11] Traps: 0 reserved, 1 osc fail, 2 address, 3 stack, 4 math.
// [RULE12] Reset bypasses vectoring, clears state, program counter starts at zero.
// [RULE13] Interrupt entry and return each take a fixed number of cycles.
// [RULE14] Fetch address is table base plus twice the vector number.
`default_nettype none
module evc_controller
    import evc_pkg::*;
#(
    parameter int N_IRQ = NUM_IRQS,
    parameter logic [3:0] ENTRY_LAT = ENTRY_CYCLES,
    parameter logic [3:0] RETURN_LAT = RETURN_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [NUM_TRAPS-1:0] trap_req,
    input wire logic [N_IRQ-1:0] irq_req,
    input wire logic [N_IRQ*PRIO_W-1:0] irq_prio,
    input wire logic [PRIO_W-1:0] cpu_prio,
    input wire logic alt_table_select,
    input wire logic int_ack,
    input wire logic ret_req,
    output logic int_req,
    output logic [VEC_W-1:0] vec_num,
    output logic [ADDR_W-1:0] vec_fetch_addr,
    output logic [LEVEL_W-1:0] vec_level,
    output logic vec_is_trap,
    output logic entry_done,
    output logic in_service,
    output logic return_done,
    output logic pc_load,
    output logic [ADDR_W-1:0] pc_value
);
    // Whole state of the controller
    typedef struct packed {
        evc_state_t state;
        logic [3:0] cnt;
        logic [VEC_W-1:0] vec;
        logic [ADDR_W-1:0] addr;
        logic [LEVEL_W-1:0] level;
        logic trap;
        logic entry_done;
        logic return_done;
        logic pc_load;
        logic [ADDR_W-1:0] pc;
    } evc_regs_t;

    evc_regs_t r;
    evc_regs_t next_r;

    logic win_valid;
    logic [VEC_W-1:0] win_vec;
    logic [LEVEL_W-1:0] win_level;
    logic [ADDR_W-1:0] win_addr;
    logic outranks_cpu;

    // Winner among traps and enabled interrupts
    evc_arbiter #(
        .N_IRQ(N_IRQ)
    ) u_arbiter (
        .trap_pend(trap_req),
        .irq_pend(irq_req),
        .irq_prio(irq_prio),
        .win_valid(win_valid),
        .win_vec(win_vec),
        .win_level(win_level)
    );

    // Table address of the winner; the select bit is read live
    evc_vector_addr u_vector_addr (
        .vec_num(win_vec),
        .alt_table_select(alt_table_select),
        .fetch_addr(win_addr)
    );

    // Traps always outrank the CPU; interrupts only above its level
    always_comb begin
        outranks_cpu = win_valid && (win_level > {1'b0, cpu_prio}); // [RULE3]
    end

    // Single merged request, only while idle
    always_comb begin
        int_req = (r.state == EVC_IDLE) && outranks_cpu; // [RULE1]
    end

    // Next-state logic
    always_comb begin
        next_r = r;
        next_r.entry_done = 1'b0;
        next_r.return_done = 1'b0;
        next_r.pc_load = 1'b0;
        case (r.state)
            EVC_BOOT: begin
                // Reset load of the program counter, no vector fetch
                next_r.pc_load = 1'b1; // [RULE12]
                next_r.pc = RESET_PC; // [RULE12]
                next_r.state = EVC_IDLE;
            end
            EVC_IDLE: begin
                // Latch the winner at the moment the CPU accepts
                if (int_ack && int_req) begin
                    next_r.vec = win_vec; // [RULE7]
                    next_r.addr = win_addr; // [RULE9] [RULE14]
                    next_r.level = win_level;
                    next_r.trap = (win_level == TRAP_LEVEL); // [RULE11]
                    next_r.cnt = ENTRY_LAT - 4'h1;
                    next_r.state = EVC_ENTRY;
                end
            end
            EVC_ENTRY: begin
                // Fixed entry latency, independent of the source
                if (r.cnt == 4'h0) begin // [RULE13]
                    next_r.entry_done = 1'b1;
                    next_r.state = EVC_SERVE;
                end else begin
                    next_r.cnt = r.cnt - 4'h1;
                end
            end
            EVC_SERVE: begin
                // Routine runs until the CPU asks to return
                if (ret_req) begin
                    next_r.cnt = RETURN_LAT - 4'h1;
                    next_r.state = EVC_RETURN;
                end
            end
            EVC_RETURN: begin
                // Fixed return latency
                if (r.cnt == 4'h0) begin // [RULE13]
                    next_r.return_done = 1'b1;
                    next_r.state = EVC_IDLE;
                end else begin
                    next_r.cnt = r.cnt - 4'h1;
                end
            end
            default: begin
                // Illegal code: recover through the reset path
                next_r.state = EVC_BOOT;
            end
        endcase
    end

    // State register; clock enable freezes everything
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r.state <= EVC_BOOT; // [RULE12]
            r.cnt <= 4'h0;
            r.vec <= 7'h00;
            r.addr <= 24'h000000;
            r.level <= 4'h0;
            r.trap <= 1'b0;
            r.entry_done <= 1'b0;
            r.return_done <= 1'b0;
            r.pc_load <= 1'b0;
            r.pc <= RESET_PC;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // Registered outputs
    always_comb begin
        vec_num = r.vec;
        vec_fetch_addr = r.addr; // [RULE8]
        vec_level = r.level;
        vec_is_trap = r.trap;
        entry_done = r.entry_done;
        return_done = r.return_done;
        in_service = (r.state == EVC_SERVE);
        pc_load = r.pc_load;
        pc_value = r.pc;
    end
endmodule
`default_nettype wire

// *** evc_controller_assertions.sv ***
`default_nettype none
module evc_controller_assertions
    import evc_pkg::*;
#(
    parameter int N_IRQ = NUM_IRQS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [NUM_TRAPS-1:0] trap_req,
    input wire logic [N_IRQ-1:0] irq_req,
    input wire logic [PRIO_W-1:0] cpu_prio,
    input wire logic alt_table_select,
    input wire logic int_ack,
    input wire logic ret_req,
    input wire logic int_req,
    input wire logic [VEC_W-1:0] vec_num,
    input wire logic [ADDR_W-1:0] vec_fetch_addr,
    input wire logic [LEVEL_W-1:0] vec_level,
    input wire logic vec_is_trap,
    input wire logic entry_done,
    input wire logic in_service,
    input wire logic return_done,
    input wire logic pc_load,
    input wire logic [ADDR_W-1:0] pc_value
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Accepted entry and accepted return
    wire take = ce && int_req && int_ack;
    wire back = ce && ret_req && in_service;
    wire [23:0] off = {16'h0, vec_num, 1'b0};
    // Pulse is registered on the third edge after the take, so seen on the fourth sample
    chk_entry_lat: assert property (take |-> ##3 !entry_done ##1 entry_done)
        else $error("entry latency wrong");
    chk_ret_lat: assert property (back |-> ##3 !return_done ##1 return_done)
        else $error("return latency wrong");
    chk_svc_drop: assert property (back |=> !in_service)
        else $error("service level stuck");
    chk_req_drop: assert property (take |=> !int_req)
        else $error("request not dropped");
    chk_merge_src: assert property (int_req |-> (|trap_req) || (|irq_req))
        else $error("request without source");
    chk_pri_addr: assert property (take && !alt_table_select |=>
        vec_fetch_addr == 24'h000004 + off) else $error("primary address wrong");
    chk_alt_addr: assert property (take && alt_table_select |=>
        vec_fetch_addr == 24'h000104 + off) else $error("alternate address wrong");
    chk_trap_lvl: assert property (take && (|trap_req) |=>
        vec_is_trap && vec_level == 4'h8 && vec_num < 7'h08) else $error("trap wrong");
    chk_prio_gate: assert property (take && !(|trap_req) |=>
        !vec_is_trap && vec_level > {1'b0, $past(cpu_prio)}) else $error("level wrong");
    // Load lands one edge after release, so reset was still high two samples back
    chk_pc_zero: assert property (pc_load |-> pc_value == 24'h0 && $past(rst, 2))
        else $error("reset load wrong");
    cover property (take && alt_table_select);
    cover property (take && (|trap_req));
    cover property (back);
endmodule
`default_nettype wire

// *** evc_cpu_model.sv ***
`default_nettype none
module evc_cpu_model (
    input wire logic clk,
    input wire logic int_req,
    input wire logic in_service,
    input wire logic [7:0] svc_wait,
    output logic int_ack,
    output logic ret_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt;
    initial begin
        int_ack = 1'b0;
        ret_req = 1'b0;
        cnt = 8'h00;
    end
    // Ack at once; stay in the routine svc_wait+1 cycles, so slow cores are modelled too
    always @(negedge clk) begin
        int_ack <= int_req && !int_ack;
        cnt <= in_service ? cnt + 8'h01 : 8'h00;
        ret_req <= in_service && !ret_req && cnt >= svc_wait;
    end
endmodule
`default_nettype wire

// *** evc_controller_tb_top.sv ***
`default_nettype none
module evc_controller_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import evc_pkg::*;
    localparam int N_IRQ = 8;
    logic clk = 1'b0, rst = 1'b1, alt = 1'b0, int_ack, ret_req, int_req, vec_is_trap;
    logic entry_done, in_service, return_done, pc_load;
    logic [7:0] trap_req = 8'h00, irq_req = 8'h00, svc_wait = 8'h02;
    logic [23:0] irq_prio = 24'h0, vec_fetch_addr, pc_value;
    logic [2:0] cpu_prio = 3'h0;
    logic [6:0] vec_num;
    logic [3:0] vec_level;
    int n_mismatch = 0, checked = 0;
    always #4 clk = ~clk;
    evc_controller #(.N_IRQ(N_IRQ)) u_evc_controller (.clk(clk), .rst(rst), .ce(1'b1),
        .trap_req(trap_req), .irq_req(irq_req), .irq_prio(irq_prio), .cpu_prio(cpu_prio),
        .alt_table_select(alt), .int_ack(int_ack), .ret_req(ret_req), .int_req(int_req),
        .vec_num(vec_num), .vec_fetch_addr(vec_fetch_addr), .vec_level(vec_level),
        .vec_is_trap(vec_is_trap), .entry_done(entry_done), .in_service(in_service),
        .return_done(return_done), .pc_load(pc_load), .pc_value(pc_value));
    evc_cpu_model u_evc_cpu_model (.clk(clk), .int_req(int_req), .in_service(in_service),
        .svc_wait(svc_wait), .int_ack(int_ack), .ret_req(ret_req));
    task chk(input string name, input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task end_sim;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Wait for entry, judge the vector, then let the core return
    task serve(input logic [6:0] v, input logic [3:0] lvl);
        int i;
        for (i = 0; i < 40 && entry_done !== 1'b1; i++) @(negedge clk);
        chk("entry_done", {23'h0, entry_done}, 24'h1);
        chk("in_service", {23'h0, in_service}, 24'h1);
        chk("vec_num", {17'h0, vec_num}, {17'h0, v});
        chk("fetch", vec_fetch_addr, (alt ? 24'h104 : 24'h4) + {16'h0, v, 1'b0});
        chk("level", {20'h0, vec_level}, {20'h0, lvl});
        chk("is_trap", {23'h0, vec_is_trap}, {23'h0, v < 7'h08});
        trap_req = 8'h00;
        irq_req = 8'h00;
        for (i = 0; i < 60 && return_done !== 1'b1; i++) @(negedge clk);
        chk("return_done", {23'h0, return_done}, 24'h1);
        chk("svc_left", {23'h0, in_service}, 24'h0);
    endtask
    task t_reset;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("pc_load", {23'h0, pc_load}, 24'h1);
        chk("pc_value", pc_value, 24'h0);
    endtask
    // All traps from n upward plus a top-level interrupt; odd n use the alternate table
    task t_traps;
        for (int n = 0; n < 8; n++) begin
            alt = n[0];
            trap_req = 8'hFF << n;
            irq_req = 8'h01;
            irq_prio[2:0] = 3'h7;
            serve(n[6:0], 4'h8);
        end
        alt = 1'b0;
    endtask
    task t_tie;
        irq_prio = {8{3'h5}};
        irq_req = 8'hC4;
        serve(7'd10, 4'h5);
    endtask
    // Higher level beats lower vector; a level not above the core's is held off
    task t_prio;
        svc_wait = 8'h14;
        irq_prio = 24'h0;
        irq_prio[5:3] = 3'h2;
        irq_prio[20:18] = 3'h6;
        cpu_prio = 3'h3;
        irq_req = 8'h42;
        serve(7'd14, 4'h6);
        cpu_prio = 3'h2;
        irq_req = 8'h03;
        repeat (8) @(negedge clk);
        chk("int_req", {23'h0, int_req}, 24'h0);
        cpu_prio = 3'h1;
        serve(7'd9, 4'h2);
    endtask
    // Reset inside a long routine must drop service and reload the program counter
    task t_midreset;
        svc_wait = 8'h28;
        trap_req = 8'h10;
        for (int i = 0; i < 20 && in_service !== 1'b1; i++) @(negedge clk);
        chk("mid_service", {23'h0, in_service}, 24'h1);
        trap_req = 8'h00;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        chk("rst_service", {23'h0, in_service}, 24'h0);
        chk("rst_vec", {17'h0, vec_num}, 24'h0);
        rst = 1'b0;
        @(negedge clk);
        chk("rst_pc_load", {23'h0, pc_load}, 24'h1);
        chk("rst_pc_value", pc_value, 24'h0);
        @(negedge clk);
        chk("rst_pc_pulse", {23'h0, pc_load}, 24'h0);
        svc_wait = 8'h02;
    endtask
    initial begin
        t_reset();
        t_traps();
        t_tie();
        t_prio();
        t_midreset();
        end_sim();
    end
    // Hang guard, well above the few hundred cycles needed
    initial begin
        #30000;
        n_mismatch++;
        end_sim();
    end
endmodule
bind evc_controller evc_controller_assertions #(.N_IRQ(N_IRQ)) u_evc_controller_assertions (
    .clk(clk), .rst(rst), .ce(ce), .trap_req(trap_req), .irq_req(irq_req),
    .cpu_prio(cpu_prio), .alt_table_select(alt_table_select), .int_ack(int_ack),
    .ret_req(ret_req), .int_req(int_req), .vec_num(vec_num), .vec_fetch_addr(vec_fetch_addr),
    .vec_level(vec_level), .vec_is_trap(vec_is_trap), .entry_done(entry_done),
    .in_service(in_service), .return_done(return_done), .pc_load(pc_load),
    .pc_value(pc_value));
`default_nettype wire
